// file: include/tws_pkg.sv
// shared constants, types and address table for the two-wire sensor slave
package tws_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int MCLK_PERIOD_NS = 10;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / MCLK_PERIOD_NS;

    // ****************************************
    // register pointers, fields, reset values
    // ****************************************
    localparam logic [7:0] PTR_TEMP_HI = 8'h00;
    localparam logic [7:0] PTR_TEMP_LO = 8'h10;
    localparam logic [7:0] PTR_CONFIG1 = 8'h09;
    localparam logic [7:0] CONFIG1_RST = 8'h00;
    localparam int SD_BIT = 6;
    localparam int FAULT_BIT = 0;
    localparam int SUPPLY_BIT = 1;
    localparam logic [7:0] SHORT_TEMP_HI = 8'hc0;
    localparam logic [7:0] RESULT_RST = 8'h00;

    // ****************************************
    // address options
    // ****************************************
    localparam logic [6:0] ADDR_FLOAT_FLOAT = 7'h2a;
    localparam logic [6:0] ADDR_UFLOAT_BASE = 7'h1c;
    localparam logic [6:0] ADDR_LFLOAT_BASE = 7'h1e;
    localparam logic [6:0] ADDR_STRAP_BASE = 7'h4c;

    typedef enum logic [1:0] {STRAP_LOW = 2'b00, STRAP_HIGH = 2'b01, STRAP_FLOAT = 2'b10} tws_strap_t;
    typedef enum logic [1:0] {VAR_SINGLE = 2'b00, VAR_DUAL = 2'b01, VAR_PRESET = 2'b10} tws_variant_t;
    typedef enum logic [1:0] {LK_ADDR = 2'b00, LK_WRITE = 2'b01, LK_READ = 2'b10, LK_IGNORE = 2'b11} tws_link_t;
    typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_START = 2'b01, CV_BUSY = 2'b10} tws_conv_t;

    // nine-way strap decode
    function automatic logic [6:0] tws_strap_addr(input tws_strap_t up, input tws_strap_t lo);
        if (up == STRAP_FLOAT && lo == STRAP_FLOAT) return ADDR_FLOAT_FLOAT;
        if (up == STRAP_FLOAT) return {ADDR_UFLOAT_BASE[6:1], lo == STRAP_HIGH};
        if (lo == STRAP_FLOAT) return {ADDR_LFLOAT_BASE[6:1], up == STRAP_HIGH};
        return {ADDR_STRAP_BASE[6:2], up == STRAP_HIGH, lo == STRAP_HIGH};
    endfunction : tws_strap_addr

endpackage : tws_pkg

// file: verilog/tws_sync.sv
// two-flop level synchroniser into the mclk domain
module tws_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : tws_sync

// file: verilog/tws_chan.sv
// one channel's temperature result register pair
module tws_chan (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // conversion result
    input wire logic load,
    input wire logic [11:0] raw,
    input wire logic fault,
    input wire logic short_in,
    input wire logic supply_bad_conv,
    input wire logic supply_bad_set,
    // stored bytes
    output logic [7:0] hi,
    output logic [7:0] lo
);

    // store result; a short reads as the lowest temperature
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hi <= tws_pkg::RESULT_RST;
            lo <= tws_pkg::RESULT_RST;
        end else if (load) begin
            hi <= short_in ? tws_pkg::SHORT_TEMP_HI : raw[11:4]; // R2
            lo <= {short_in ? 4'h0 : raw[3:0], 2'b00, supply_bad_conv | supply_bad_set, fault}; // R1
        end else if (supply_bad_set) begin
            lo[tws_pkg::SUPPLY_BIT] <= 1'b1; // R4
        end
    end

endmodule : tws_chan

// file: verilog/tws_slave.sv
// two-wire slave interface and conversion control of the temperature monitor
// Functional notes
// R1 - fault comparator watched during conversion; trip sets result bit 0
// R2 - shorted remote diode reports minus sixty-four degrees
// R3 - no conversion starts while the supply is invalid
// R4 - invalid supply sets bit 1 of every result register; here only the low bytes, and not while idle with the shutdown bit set
// R5 - either line low for 30 ms inside a frame resets the interface
// R6 - on timeout release the data line and wait for a new START
// R7 - master keeps clock at 1 kHz or faster
// R8 - shutdown request finishes the running conversion, then powers down
// R9 - shutdown clear means conversions run back to back
// R10 - serial interface keeps working in shutdown
// R11 - target only; never drives the clock line
// R12 - works from 1 kHz up to 3.4 MHz clock
// R13 - bytes shift most significant bit first
// R14 - data falling while clock high is START; transfers begin with it
// R15 - data rising while clock high is STOP; transfers end with it
// R16 - first byte is seven address bits plus direction bit last
// R17 - matched address acknowledged by low data through ninth clock high
// R18 - eight bits plus acknowledge per byte, byte count set by master
// R19 - master changes data only while clock is low
// R20 - master ends a read with a not-acknowledge
// R21 - dual variant: second transistor polarity sets address bit 0
// R22 - dual variant: first transistor polarity sets address bit 1
// R23 - single variant: two three-level straps pick one of nine addresses
// R24 - address latched at reset and at software reset
// R25 - first written byte loads pointer; reads return pointed register
// R26 - timeout counted on mclk, restarted when both lines high, stopped at STOP
module tws_slave #(
    parameter tws_pkg::tws_variant_t VARIANT = tws_pkg::VAR_DUAL,
    parameter logic [6:0] PRESET_ADDR = tws_pkg::ADDR_STRAP_BASE,
    parameter int NCH = 3,
    parameter int unsigned TIMEOUT_CYC = tws_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // two-wire bus; the clock pin is the link clock
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address selection
    input wire logic [1:0] address_strap_upper,
    input wire logic [1:0] address_strap_lower,
    input wire logic pol_ch1_swapped,
    input wire logic pol_ch2_swapped,
    input wire logic addr_relatch,
    // conversion engine
    output logic conv_start,
    output logic [((NCH > 1) ? $clog2(NCH) : 1)-1:0] conv_channel,
    input wire logic conv_done,
    input wire logic [11:0] conv_raw,
    input wire logic [NCH-1:0] diode_fault_cmp,
    input wire logic [NCH-1:0] diode_short_cmp,
    input wire logic supply_ok_cmp,
    // status
    output logic powered_down,
    output logic shutdown_request_bit,
    output logic supply_invalid_flag,
    output logic [6:0] device_address
);

    localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    // ****************************************
    // synchronisers
    // ****************************************
    logic scl_s;
    logic sda_s;
    logic supply_ok_s;
    logic [NCH-1:0] fault_s;
    logic [NCH-1:0] short_s;
    logic [5:0] strap_s;
    logic wtog;
    logic wtog_s;

    tws_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_sync_bus (
        .mclk(mclk), .rst(rst), .d({scl_in, sda_in}), .q({scl_s, sda_s}));
    tws_sync #(.WIDTH(2 * NCH + 1)) u_sync_cmp (
        .mclk(mclk), .rst(rst), .d({supply_ok_cmp, diode_fault_cmp, diode_short_cmp}),
        .q({supply_ok_s, fault_s, short_s}));
    tws_sync #(.WIDTH(6)) u_sync_strap (
        .mclk(mclk), .rst(rst),
        .d({address_strap_upper, address_strap_lower, pol_ch1_swapped, pol_ch2_swapped}), .q(strap_s));
    tws_sync #(.WIDTH(1)) u_sync_wtog (
        .mclk(mclk), .rst(rst), .d(wtog), .q(wtog_s));

    // ****************************************
    // bus condition detection (mclk)
    // ****************************************
    logic scl_q;
    logic sda_q;
    logic start_det;
    logic stop_det;
    logic frame_run;
    logic arm;
    logic timeout;
    logic [TW-1:0] low_cnt;

    // previous line levels for edge detection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign start_det = scl_s && scl_q && sda_q && !sda_s; // R14
    assign stop_det = scl_s && scl_q && !sda_q && sda_s; // R15

    // frame tracking; the link logic is held in reset outside a frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_run <= 1'b0;
            arm <= 1'b0;
        end else if (start_det) begin
            frame_run <= 1'b0; // R14
            arm <= 1'b1;
        end else if (stop_det || timeout) begin
            frame_run <= 1'b0; // R6
            arm <= 1'b0;
        end else if (arm && !scl_s) begin
            frame_run <= 1'b1;
            arm <= 1'b0;
        end
    end

    // bus-low timer, only between START and STOP
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_cnt <= '0;
        end else if (!(arm || frame_run) || (scl_s && sda_s)) begin
            low_cnt <= '0; // R26
        end else if (low_cnt != TW'(TIMEOUT_CYC - 1)) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    assign timeout = low_cnt == TW'(TIMEOUT_CYC - 1); // R5

    // ****************************************
    // address latch (mclk)
    // ****************************************
    logic [2:0] cap_pend;

    // capture on the third cycle after reset, once the strap synchroniser holds pin levels, and on each relatch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cap_pend <= 3'b100;
            device_address <= tws_pkg::ADDR_STRAP_BASE;
        end else begin
            cap_pend <= {1'b0, cap_pend[2:1]};
            if (cap_pend[0] || addr_relatch) begin // R24
                unique case (VARIANT)
                    tws_pkg::VAR_SINGLE: device_address <= tws_pkg::tws_strap_addr(
                        tws_pkg::tws_strap_t'(strap_s[5:4]), tws_pkg::tws_strap_t'(strap_s[3:2])); // R23
                    tws_pkg::VAR_DUAL: device_address <= {tws_pkg::ADDR_STRAP_BASE[6:2], strap_s[1], strap_s[0]}; // R21 R22
                    default: device_address <= PRESET_ADDR;
                endcase
            end
        end
    end

    // ****************************************
    // link logic (scl domain)
    // ****************************************
    logic link_rst_n;
    tws_pkg::tws_link_t lstate;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic matched;
    logic rw;
    logic first;
    logic rd_idx;
    logic [7:0] wbyte;
    logic wfirst;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [7:0] tx;
    logic next_oe;

    assign link_rst_n = frame_run;
    assign sda_out = 1'b0; // R11
    assign tx = rd_idx ? rd_b : rd_a;

    // bit counter and shifter, sampled on rising clock; no filter, so any bus rate is followed
    always_ff @(posedge scl_in or negedge link_rst_n) begin // R12
        if (!link_rst_n) begin
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
        end else if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0; // R18
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shreg <= {shreg[6:0], sda_in}; // R13
        end
    end

    // address match and transfer phase
    always_ff @(posedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lstate <= tws_pkg::LK_ADDR;
            matched <= 1'b0;
            rw <= 1'b0;
            first <= 1'b0;
            rd_idx <= 1'b0;
        end else if (bit_cnt == 4'h7) begin
            if (lstate == tws_pkg::LK_ADDR) begin
                matched <= shreg[6:0] == device_address; // R16
                rw <= sda_in;
            end else if (lstate == tws_pkg::LK_WRITE) begin
                first <= 1'b0;
            end
        end else if (bit_cnt == 4'h8) begin
            unique case (lstate)
                tws_pkg::LK_ADDR: begin
                    lstate <= !matched ? tws_pkg::LK_IGNORE : (rw ? tws_pkg::LK_READ : tws_pkg::LK_WRITE);
                    first <= 1'b1;
                end
                tws_pkg::LK_READ: begin
                    lstate <= sda_in ? tws_pkg::LK_IGNORE : tws_pkg::LK_READ;
                    rd_idx <= 1'b1;
                end
                tws_pkg::LK_WRITE: lstate <= tws_pkg::LK_WRITE;
                tws_pkg::LK_IGNORE: lstate <= tws_pkg::LK_IGNORE;
            endcase
        end
    end

    // written byte handed to mclk by toggle; survives frame resets
    always_ff @(posedge scl_in or posedge rst) begin
        if (rst) begin
            wtog <= 1'b0;
            wbyte <= 8'h00;
            wfirst <= 1'b0;
        end else if (link_rst_n && lstate == tws_pkg::LK_WRITE && bit_cnt == 4'h7) begin
            wtog <= !wtog;
            wbyte <= {shreg[6:0], sda_in};
            wfirst <= first; // R25
        end
    end

    // data drive, changed on falling clock, cleared at once by the frame reset
    always_comb begin
        next_oe = 1'b0;
        if (bit_cnt == 4'h8) begin
            next_oe = (lstate == tws_pkg::LK_ADDR && matched) || lstate == tws_pkg::LK_WRITE; // R17
        end else if (lstate == tws_pkg::LK_READ) begin
            next_oe = !tx[3'(3'd7 - bit_cnt[2:0])]; // R13
        end
    end

    always_ff @(negedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe <= 1'b0; // R6
        end else begin
            sda_oe <= next_oe;
        end
    end

    // ****************************************
    // pointer, configuration and read data (mclk)
    // ****************************************
    logic wtog_q;
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic [NCH-1:0][7:0] hi_all;
    logic [NCH-1:0][7:0] lo_all;

    function automatic logic [7:0] byte_at(input logic [7:0] p);
        logic [7:0] v;
        v = 8'h00;
        if (p == tws_pkg::PTR_CONFIG1) v = cfg1;
        for (int c = 0; c < NCH; c++) begin
            if (p == tws_pkg::PTR_TEMP_HI + 8'(c)) v = hi_all[c];
            if (p == tws_pkg::PTR_TEMP_LO + 8'(c)) v = lo_all[c];
        end
        return v;
    endfunction : byte_at

    // first byte of a write sets the pointer, later bytes the register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wtog_q <= 1'b0;
            ptr <= 8'h00;
            cfg1 <= tws_pkg::CONFIG1_RST;
        end else begin
            wtog_q <= wtog_s;
            if (wtog_s != wtog_q) begin
                if (wfirst) begin
                    ptr <= wbyte; // R25
                end else if (ptr == tws_pkg::PTR_CONFIG1) begin
                    cfg1 <= wbyte;
                end
            end
        end
    end

    // bytes offered to the link; second byte is the low half
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_a <= 8'h00;
            rd_b <= 8'h00;
        end else begin
            rd_a <= byte_at(ptr); // R25
            rd_b <= byte_at(ptr | tws_pkg::PTR_TEMP_LO);
        end
    end

    assign shutdown_request_bit = cfg1[tws_pkg::SD_BIT];
    assign supply_invalid_flag = lo_all[0][tws_pkg::SUPPLY_BIT];

    // ****************************************
    // conversion control (mclk)
    // ****************************************
    tws_pkg::tws_conv_t cstate;
    logic fault_seen;
    logic sup_seen;
    logic sup_set;
    logic [NCH-1:0] load;

    // idle waits on shutdown and supply; busy waits for the engine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cstate <= tws_pkg::CV_IDLE;
            conv_channel <= '0;
            fault_seen <= 1'b0;
            sup_seen <= 1'b0;
        end else begin
            unique case (cstate)
                tws_pkg::CV_IDLE: begin
                    if (!cfg1[tws_pkg::SD_BIT] && supply_ok_s) begin
                        cstate <= tws_pkg::CV_START; // R3 R9
                    end
                end
                tws_pkg::CV_START: begin
                    cstate <= tws_pkg::CV_BUSY;
                    fault_seen <= 1'b0;
                    sup_seen <= 1'b0;
                end
                tws_pkg::CV_BUSY: begin
                    fault_seen <= fault_seen | fault_s[conv_channel]; // R1
                    sup_seen <= sup_seen | !supply_ok_s;
                    if (conv_done) begin
                        cstate <= tws_pkg::CV_IDLE; // R8
                        conv_channel <= (conv_channel == CHW'(NCH - 1)) ? '0 : conv_channel + 1'b1;
                    end
                end
                default: cstate <= tws_pkg::CV_IDLE;
            endcase
        end
    end

    assign conv_start = cstate == tws_pkg::CV_START;
    assign powered_down = cstate == tws_pkg::CV_IDLE && cfg1[tws_pkg::SD_BIT]; // R8 R10
    assign sup_set = cstate == tws_pkg::CV_IDLE && !cfg1[tws_pkg::SD_BIT] && !supply_ok_s; // R4

    // result registers, one per channel
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        assign load[c] = cstate == tws_pkg::CV_BUSY && conv_done && conv_channel == CHW'(c);
        tws_chan u_chan (
            .mclk(mclk),
            .rst(rst),
            .load(load[c]),
            .raw(conv_raw),
            .fault(fault_seen | fault_s[c]),
            .short_in(short_s[c]),
            .supply_bad_conv(sup_seen | !supply_ok_s),
            .supply_bad_set(sup_set),
            .hi(hi_all[c]),
            .lo(lo_all[c])
        );
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_conv_end;
        cstate == tws_pkg::CV_BUSY && conv_done;
    endsequence

    sequence s_want_bad;
        cstate == tws_pkg::CV_IDLE && !cfg1[tws_pkg::SD_BIT] && !supply_ok_s;
    endsequence

    a_start_frame: assert property (@(posedge mclk) disable iff (rst) // R14
        start_det |=> !frame_run && arm) else $error("start did not rearm link");
    a_stop_idle: assert property (@(posedge mclk) disable iff (rst) // R15
        stop_det |=> !frame_run && !arm) else $error("stop did not idle link");
    a_timeout_release: assert property (@(posedge mclk) disable iff (rst) // R5
        timeout && !start_det |=> !frame_run ##1 !arm && low_cnt == '0) else $error("timeout kept link");
    a_timer_restart: assert property (@(posedge mclk) disable iff (rst) // R26
        scl_s && sda_s |=> low_cnt == '0) else $error("timer not restarted");
    a_shut_down: assert property (@(posedge mclk) disable iff (rst) // R8
        s_conv_end ##0 cfg1[tws_pkg::SD_BIT] |=> powered_down && !conv_start) else $error("no power down");
    a_no_bad_conv: assert property (@(posedge mclk) disable iff (rst) // R3
        conv_start |-> $past(supply_ok_s)) else $error("conversion with bad supply");
    a_continuous: assert property (@(posedge mclk) disable iff (rst) // R9
        s_conv_end ##1 (!cfg1[tws_pkg::SD_BIT] && supply_ok_s) |=> conv_start) else $error("conversion stalled");
    a_supply_flag: assert property (@(posedge mclk) disable iff (rst) // R4
        s_want_bad |=> lo_all[0][tws_pkg::SUPPLY_BIT] && lo_all[NCH-1][tws_pkg::SUPPLY_BIT])
        else $error("supply flag not set");
    a_fault_flag: assert property (@(posedge mclk) disable iff (rst) // R1
        s_conv_end ##0 fault_s[conv_channel] |=> lo_all[$past(conv_channel)][tws_pkg::FAULT_BIT])
        else $error("fault flag not set");
    a_short_temp: assert property (@(posedge mclk) disable iff (rst) // R2
        s_conv_end ##0 short_s[conv_channel] |=> hi_all[$past(conv_channel)] == tws_pkg::SHORT_TEMP_HI)
        else $error("short not reported");
    a_addr_ack: assert property (@(posedge scl_in) disable iff (!link_rst_n) // R17
        lstate == tws_pkg::LK_ADDR && bit_cnt == 4'h8 && matched |-> sda_oe) else $error("no address ack");
    a_msb_first: assert property (@(posedge scl_in) disable iff (!link_rst_n) // R13
        lstate == tws_pkg::LK_READ && bit_cnt < 4'h8 |-> sda_oe == !tx[3'(3'd7 - bit_cnt[2:0])])
        else $error("read bit out of order");

endmodule : tws_slave

// file: bench/tws_bus_master.sv
// two-wire bus master model that makes the link clock
module tws_bus_master (
    // bus lines
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // one bit of 48 ns, data moved only while clock low
    task automatic bitx(input logic b, output logic r);
        sda_m = b;
        #12;
        scl = 1'b1;
        #12;
        r = sda;
        #12;
        scl = 1'b0;
        #12;
    endtask : bitx

    // start or repeated start
    task automatic start();
        sda_m = 1'b1;
        #12;
        scl = 1'b1;
        #60;
        sda_m = 1'b0;
        #60;
        scl = 1'b0;
        #60;
    endtask : start

    task automatic stop();
        sda_m = 1'b0;
        #12;
        scl = 1'b1;
        #60;
        sda_m = 1'b1;
        #60;
    endtask : stop

    // byte out msb first, then the acknowledge slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask : wbyte

    // byte in msb first; last byte is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask : rbyte
endmodule : tws_bus_master

// file: bench/tb_top.sv
// testbench for the two-wire sensor slave
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, scl, sda_m, sda, sda_out, sda_oe, ack;
    logic pol1, pol2, relatch, conv_start, conv_done, supply_ok, powered_down, sd_bit, sup_flag;
    logic [1:0] conv_ch;
    logic [11:0] conv_raw;
    logic [2:0] fault, short_c;
    logic [6:0] dev_addr, dev, dev_single;
    logic [1:0] st_up, st_lo;
    logic [7:0] d0, d1;
    int bad_count = 0;
    int checks_done = 0;
    int n_start = 0;
    int cnt = 0;
    int n0;

    // open-drain data line with pull-up
    assign sda = sda_m & ~(sda_oe & ~sda_out);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    tws_bus_master i_mst (.scl(scl), .sda_m(sda_m), .sda(sda));

    tws_slave #(.TIMEOUT_CYC(2000)) i_dut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_upper(2'b00), .address_strap_lower(2'b00), .pol_ch1_swapped(pol1),
        .pol_ch2_swapped(pol2), .addr_relatch(relatch), .conv_start(conv_start), .conv_channel(conv_ch),
        .conv_done(conv_done), .conv_raw(conv_raw), .diode_fault_cmp(fault), .diode_short_cmp(short_c),
        .supply_ok_cmp(supply_ok), .powered_down(powered_down), .shutdown_request_bit(sd_bit),
        .supply_invalid_flag(sup_flag), .device_address(dev_addr));

    // single-variant copy: only its strap decode is looked at
    tws_slave #(.VARIANT(tws_pkg::VAR_SINGLE), .TIMEOUT_CYC(2000)) i_dut_single (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(),
        .address_strap_upper(st_up), .address_strap_lower(st_lo), .pol_ch1_swapped(1'b0),
        .pol_ch2_swapped(1'b0), .addr_relatch(relatch), .conv_start(), .conv_channel(),
        .conv_done(1'b0), .conv_raw(12'h000), .diode_fault_cmp(3'b000), .diode_short_cmp(3'b000),
        .supply_ok_cmp(supply_ok), .powered_down(), .shutdown_request_bit(), .supply_invalid_flag(),
        .device_address(dev_single));

    // conversion engine: done five cycles after each start
    always @(posedge mclk) begin
        conv_done <= 1'b0;
        if (conv_start === 1'b1) begin
            cnt <= 5;
            n_start <= n_start + 1;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            conv_done <= (cnt == 1);
            conv_raw <= {4'h1, 4'h9 + 4'(conv_ch), 4'h5};
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // pointer then one data byte
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] val);
        i_mst.start();
        i_mst.wbyte({dev, 1'b0}, ack);
        chk(8'(ack), 8'h01);
        i_mst.wbyte(ptr, ack);
        i_mst.wbyte(val, ack);
        chk(8'(ack), 8'h01);
        i_mst.stop();
    endtask : wr_reg

    // pointer, repeated start, two bytes read
    task automatic rd_reg(input logic [7:0] ptr);
        i_mst.start();
        i_mst.wbyte({dev, 1'b0}, ack);
        i_mst.wbyte(ptr, ack);
        i_mst.start();
        i_mst.wbyte({dev, 1'b1}, ack);
        chk(8'(ack), 8'h01);
        i_mst.rbyte(1'b0, d0);
        i_mst.rbyte(1'b1, d1);
        i_mst.stop();
    endtask : rd_reg

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // watchdog for a hung run
    initial begin
        #400000;
        bad_count++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        pol1 = 1'b1;
        pol2 = 1'b0;
        relatch = 1'b0;
        st_up = 2'b10;
        st_lo = 2'b01;
        fault = 3'b010;
        short_c = 3'b100;
        supply_ok = 1'b1;
        dev = 7'h4e;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(8'(dev_addr), 8'h4e);
        chk(8'(dev_single), 8'h1d);
        pol1 <= 1'b0;
        pol2 <= 1'b1;
        st_up <= 2'b01;
        st_lo <= 2'b10;
        repeat (5) @(posedge mclk);
        relatch <= 1'b1;
        @(posedge mclk);
        relatch <= 1'b0;
        repeat (5) @(posedge mclk);
        chk(8'(dev_addr), 8'h4d);
        chk(8'(dev_single), 8'h1f);
        dev = 7'h4d;
        rd_reg(8'h00);
        chk(d0, 8'h19);
        chk(d1, 8'h50);
        rd_reg(8'h01);
        chk(d1 & 8'h01, 8'h01);
        rd_reg(8'h02);
        chk(d0, 8'hc0);
        // foreign address and high-speed code get no acknowledge
        i_mst.start();
        i_mst.wbyte(8'h98, ack);
        chk(8'(ack), 8'h00);
        i_mst.start();
        i_mst.wbyte(8'h08, ack);
        chk(8'(ack), 8'h00);
        i_mst.stop();
        wr_reg(8'h09, 8'h40);
        repeat (50) @(posedge mclk);
        chk(8'(sd_bit), 8'h01);
        chk(8'(powered_down), 8'h01);
        n0 = n_start;
        rd_reg(8'h09);
        chk(d0, 8'h40);
        chk(8'(n_start - n0), 8'h00);
        wr_reg(8'h09, 8'h00);
        repeat (50) @(posedge mclk);
        chk(8'(n_start > n0 + 2), 8'h01);
        supply_ok <= 1'b0;
        repeat (20) @(posedge mclk);
        n0 = n_start;
        repeat (100) @(posedge mclk);
        chk(8'(sup_flag), 8'h01);
        chk(8'(n_start - n0), 8'h00);
        supply_ok <= 1'b1;
        // clock held low while the device acknowledges
        i_mst.start();
        d1 = {dev, 1'b0};
        for (int i = 7; i >= 0; i--) begin
            i_mst.bitx(d1[i], ack);
        end
        #18000;
        chk(8'(sda_oe), 8'h01);
        #4000;
        chk(8'(sda_oe), 8'h00);
        i_mst.stop();
        wr_reg(8'h09, 8'h00);
        close_out();
    end
endmodule : tb_top
